// ---- verification/sbg_host.sv ----
`timescale 1ns/10ps
module sbg_host (
    input wire logic ref_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // Clock stands high between frames, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Quarter of a 160 ns bit
    task automatic q();
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_pull <= ~b;
        q();
        scl <= 1'b1;
        q();
        s = sda_line;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        q();
        q(); // Let the slave drop its acknowledge before clock rises
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask
    // MSB first; d of 8'hff releases data so the slave can drive it
    task automatic xfer(input logic [7:0] d, input logic ak,
        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ak, a);
    endtask
    task automatic blk_wr(input logic [6:0] a, input logic [7:0] n,
        input logic [7:0] x, input logic [7:0] d [4], output logic nak);
        logic [7:0] r;
        logic k;
        start();
        xfer({a, 1'b0}, 1'b1, r, nak);
        xfer(n, 1'b1, r, k);
        nak |= k;
        xfer(x, 1'b1, r, k);
        nak |= k;
        for (int i = 0; i < x; i++) begin
            xfer(d[i], 1'b1, r, k);
            nak |= k;
        end
        stop();
    endtask
    task automatic blk_rd(input logic [6:0] a, input logic [7:0] n,
        input int m, output logic [7:0] c, output logic [7:0] d [4],
        output logic nak);
        logic [7:0] r;
        logic k;
        start();
        xfer({a, 1'b0}, 1'b1, r, nak);
        xfer(n, 1'b1, r, k);
        nak |= k;
        start();
        xfer({a, 1'b1}, 1'b1, r, k);
        nak |= k;
        xfer(8'hff, 1'b0, c, k);
        for (int i = 0; i < m; i++) begin
            xfer(8'hff, i == m - 1, d[i], k);
        end
        stop();
    endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/10ps
module tb;
    localparam logic [6:0] ADR = sbg_pkg::SBG_ADDR_SEL1;
    logic ref_clk, resetn, sda_out, sda_oe, sda_line, scl, sda_pull;
    logic sel, en0_n, en1_n;
    logic [1:0] run0, lvl0, oe0, run1, lvl1, oe1;
    logic [7:0] c;
    logic [7:0] d [4];
    logic k;
    int n_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    assign sda_line = !(sda_pull || (sda_oe && !sda_out));
    sbg_host host_u (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
        .sda_pull(sda_pull));
    sbg_slave dut_u (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_select_pin(sel), .diff_out0_en_n(en0_n),
        .diff_out1_en_n(en1_n), .diff_out0_run(run0),
        .diff_out0_level(lvl0), .diff_out0_oe(oe0), .diff_out1_run(run1),
        .diff_out1_level(lvl1), .diff_out1_oe(oe1));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic wr1(input logic [7:0] n, input logic [7:0] v);
        d[0] = v;
        host_u.blk_wr(ADR, n, 8'h01, d, k);
        repeat (12) @(posedge ref_clk);
    endtask
    task automatic t_defaults();
        check(run0, 2'b11);
        check(run1, 2'b11);
        host_u.blk_rd(ADR, 8'h00, 1, c, d, k);
        check(k, 1'b0);
        check(c, sbg_pkg::SBG_COUNT_RST);
        check(d[0], sbg_pkg::SBG_GATE_RST);
    endtask
    task automatic t_refuse();
        d = '{8'h00, 8'h00, 8'h00, 8'h00};
        host_u.blk_wr(sbg_pkg::SBG_ADDR_SEL0, 8'h00, 8'h01, d, k);
        check(k, 1'b1);
    endtask
    task automatic t_stream();
        d = '{8'h11, 8'h22, 8'h33, 8'h00};
        host_u.blk_wr(ADR, 8'h09, 8'h03, d, k);
        check(k, 1'b0);
        host_u.blk_rd(ADR, 8'h08, 4, c, d, k);
        check(d[0], sbg_pkg::SBG_COUNT_RST);
        check(d[1], 8'h11);
        check(d[2], 8'h22);
        check(d[3], 8'h33);
    endtask
    task automatic t_gate();
        logic [1:0] v;
        wr1(8'h00, 8'hfb);
        for (int i = 0; i < 4; i++) begin
            v = 2'(i);
            wr1(8'h0b, {6'h00, v});
            check(run1, 2'b00);
            check(run0, 2'b11);
            check(lvl1,
                (v == sbg_pkg::SBG_DIS_HIGH) ? 2'b11 : 2'b00);
            check(oe1,
                (v == sbg_pkg::SBG_DIS_HIZ) ? 2'b00 : 2'b11);
        end
        host_u.blk_rd(ADR, 8'h00, 1, c, d, k);
        check(d[0], 8'h02);
    endtask
    task automatic t_pins();
        wr1(8'h00, 8'h06);
        en1_n <= 1'b1;
        repeat (10) @(posedge ref_clk);
        check(run1, 2'b00);
        check(run0, 2'b11);
        check(lvl1, 2'b11);
        check(oe1, 2'b11);
        check(lvl0, 2'b00);
        check(oe0, 2'b11);
        en1_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check(run1, 2'b11);
    endtask
    task automatic t_count();
        wr1(8'h08, 8'h02);
        host_u.blk_rd(ADR, 8'h00, 2, c, d, k);
        check(c, 8'h02);
        check(d[1], 8'h00);
    endtask
    initial begin
        resetn = 1'b0;
        sel = 1'b1;
        en0_n = 1'b0;
        en1_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_defaults();
        t_refuse();
        t_stream();
        t_gate();
        t_pins();
        t_count();
        give_verdict();
    end
endmodule

// ---- verilog/sbg_pkg.sv ----
package sbg_pkg;
    localparam logic [6:0] SBG_ADDR_SEL0 = 7'h68;
    localparam logic [6:0] SBG_ADDR_SEL1 = 7'h6A;
    localparam logic [3:0] SBG_REG_GATE = 4'h0;
    localparam logic [3:0] SBG_REG_COUNT = 4'h8;
    localparam logic [3:0] SBG_REG_DIS = 4'hB;
    localparam int SBG_NREGS = 16;
    localparam int SBG_OE1_BIT = 2;
    localparam int SBG_OE0_BIT = 1;
    localparam logic [7:0] SBG_GATE_RST = 8'h06;
    localparam logic [7:0] SBG_GATE_RW_MASK = 8'h06;
    localparam logic [7:0] SBG_COUNT_RST = 8'h08;
    localparam logic [7:0] SBG_DIS_RST = 8'h00;
    localparam logic [1:0] SBG_DIS_LOW0 = 2'h0;
    localparam logic [1:0] SBG_DIS_HIZ = 2'h1;
    localparam logic [1:0] SBG_DIS_LOW2 = 2'h2;
    localparam logic [1:0] SBG_DIS_HIGH = 2'h3;
    typedef enum logic [2:0] {
        SBG_IDLE = 3'b000,
        SBG_RX = 3'b001,
        SBG_RX_ACK = 3'b010,
        SBG_TX = 3'b011,
        SBG_TX_ACK = 3'b100,
        SBG_SKIP = 3'b101
    } sbg_state_t;
endpackage

// ---- verilog/sbg_regmem.sv ----
`timescale 1ns/10ps
module sbg_regmem (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [7:0] gate_reg,
    output logic [7:0] count_reg,
    output logic [7:0] dis_reg
);
    logic [7:0] mem [sbg_pkg::SBG_NREGS];
    genvar i;
    generate
        for (i = 0; i < sbg_pkg::SBG_NREGS; i++) begin : g_reg
            localparam logic [7:0] RST =
                (i == sbg_pkg::SBG_REG_GATE) ? sbg_pkg::SBG_GATE_RST :
                (i == sbg_pkg::SBG_REG_COUNT) ? sbg_pkg::SBG_COUNT_RST :
                8'h00;
            localparam logic [7:0] MASK =
                (i == sbg_pkg::SBG_REG_GATE) ?
                sbg_pkg::SBG_GATE_RW_MASK : 8'hFF;
            wire hit = wr_en && (wr_idx == 4'(i));
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    mem[i] <= RST;
                end else if (hit) begin
                    // Reserved bits keep their fixed value
                    mem[i] <= (wr_data & MASK) | (RST & ~MASK); // [RULE_19]
                end
            end
        end
    endgenerate
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_idx];
        end
    end
    assign gate_reg = mem[sbg_pkg::SBG_REG_GATE];
    assign count_reg = mem[sbg_pkg::SBG_REG_COUNT];
    assign dis_reg = mem[sbg_pkg::SBG_REG_DIS];
endmodule

// ---- verilog/sbg_slave.sv ----
`timescale 1ns/10ps
// How it works
// [RULE_01] Start then our address with write bit; we acknowledge the address.
// [RULE_02] Byte after address is start index N; acknowledged, used first.
// [RULE_03] In a block write the next byte is count X; acknowledged.
// [RULE_04] X data bytes go to N..N+X-1, each acknowledged.
// [RULE_05] Host ends a block write with stop.
// [RULE_06] Read: index write, repeated start, read address, acknowledged.
// [RULE_07] First byte returned in a read is the count X.
// [RULE_08] Then registers N upward to N+X-1 are returned.
// [RULE_09] Returned count comes from the byte count register at index 8.
// [RULE_10] Host acknowledges every read byte except the last.
// [RULE_11] Host not-acknowledges the last byte; we release data then.
// [RULE_12] Slave address chosen by latching the address select pin.
// [RULE_13] Register 0 bit 2 enables output 1; resets to 1.
// [RULE_14] Register 0 bit 1 enables output 0; resets to 1.
// [RULE_15] Cleared enable overrides pin; output shows disabled-state field.
// [RULE_16] Disabled field: 00 low, 01 high-Z, 10 low, 11 high.
// [RULE_17] Register index advances by one after each data byte.
// [RULE_18] Output runs only when bit is 1 and enable pin low.
// [RULE_19] Reserved bits of register 0 ignore writes, read fixed.
module sbg_slave (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic address_select_pin,
    input wire logic diff_out0_en_n,
    input wire logic diff_out1_en_n,
    output logic [1:0] diff_out0_run,
    output logic [1:0] diff_out0_level,
    output logic [1:0] diff_out0_oe,
    output logic [1:0] diff_out1_run,
    output logic [1:0] diff_out1_level,
    output logic [1:0] diff_out1_oe
);
    // Two-flop synchronisers; stage one only feeds stage two
    logic [1:0] scl_sy, sda_sy, sel_sy, en0_sy, en1_sy;
    logic scl_d, sda_d;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sy <= 2'b11;
            sda_sy <= 2'b11;
            sel_sy <= 2'b00;
            en0_sy <= 2'b11;
            en1_sy <= 2'b11;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], scl_in};
            sda_sy <= {sda_sy[0], sda_in};
            sel_sy <= {sel_sy[0], address_select_pin};
            en0_sy <= {en0_sy[0], diff_out0_en_n};
            en1_sy <= {en1_sy[0], diff_out1_en_n};
            scl_d <= scl_sy[1];
            sda_d <= sda_sy[1];
        end
    end
    wire scl = scl_sy[1];
    wire sda = sda_sy[1];
    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire start_cond = scl && scl_d && sda_d && !sda;
    wire stop_cond = scl && scl_d && !sda_d && sda;

    // Address select caught once the synchroniser holds the real pin level;
    // sampling at the first edge would latch the reset value instead
    logic sel_taken, addr_sel;
    logic [1:0] sel_fill;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_taken <= 1'b0;
            addr_sel <= 1'b0;
            sel_fill <= 2'b00;
        end else begin
            sel_fill <= {sel_fill[0], 1'b1};
            if (sel_fill[1] && !sel_taken) begin
                sel_taken <= 1'b1;
                addr_sel <= sel_sy[1]; // [RULE_12]
            end
        end
    end
    wire [6:0] my_addr = addr_sel ? sbg_pkg::SBG_ADDR_SEL1
                                  : sbg_pkg::SBG_ADDR_SEL0;

    sbg_pkg::sbg_state_t state, next_state;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] phase;   // 0 addr, 1 index, 2 count, 3 data
    logic reading, sent_count, acking;
    logic [3:0] idx;
    logic [7:0] remain;
    logic [7:0] rd_data, gate_reg, count_reg, dis_reg;

    wire [7:0] rx_byte = {shreg[6:0], sda};
    wire last_bit = scl_rise && bitcnt == 3'd7;
    wire addr_hit = rx_byte[7:1] == my_addr;
    // Writes land only in the data phase while count remains
    wire wr_en = state == sbg_pkg::SBG_RX && last_bit && phase == 2'd3
                 && remain != 8'd0; // [RULE_04]
    wire [7:0] tx_byte =
        sent_count ? rd_data : count_reg; // [RULE_07] [RULE_09]

    sbg_regmem u_mem (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .wr_en(wr_en),
        .wr_idx(idx),
        .wr_data(rx_byte),
        .rd_idx(idx),
        .rd_data(rd_data),
        .gate_reg(gate_reg),
        .count_reg(count_reg),
        .dis_reg(dis_reg)
    );

    always_comb begin
        next_state = state;
        case (state)
            sbg_pkg::SBG_IDLE: next_state = sbg_pkg::SBG_IDLE;
            sbg_pkg::SBG_RX: if (last_bit) begin
                if (phase == 2'd0 && !addr_hit) begin
                    next_state = sbg_pkg::SBG_SKIP;
                end else begin
                    next_state = sbg_pkg::SBG_RX_ACK;
                end
            end
            sbg_pkg::SBG_RX_ACK: if (scl_fall && acking) begin
                next_state = reading ? sbg_pkg::SBG_TX : sbg_pkg::SBG_RX;
            end
            sbg_pkg::SBG_TX: if (scl_fall && bitcnt == 3'd7) begin
                next_state = sbg_pkg::SBG_TX_ACK;
            end
            sbg_pkg::SBG_TX_ACK: if (scl_rise && sda) begin
                // Not-acknowledge ends our drive of data
                next_state = sbg_pkg::SBG_SKIP; // [RULE_11]
            end else if (scl_fall) begin
                // Next byte waits for the end of the ack clock, else it slips
                next_state = sbg_pkg::SBG_TX; // [RULE_10]
            end
            sbg_pkg::SBG_SKIP: next_state = sbg_pkg::SBG_SKIP;
            default: next_state = sbg_pkg::SBG_IDLE;
        endcase
        if (start_cond) begin
            next_state = sbg_pkg::SBG_RX; // [RULE_06]
        end else if (stop_cond) begin
            next_state = sbg_pkg::SBG_IDLE; // [RULE_05]
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state <= sbg_pkg::SBG_IDLE;
            bitcnt <= 3'd0;
            shreg <= 8'h00;
            phase <= 2'd0;
            reading <= 1'b0;
            sent_count <= 1'b0;
            acking <= 1'b0;
            idx <= 4'h0;
            remain <= 8'h00;
        end else begin
            state <= next_state;
            if (start_cond) begin
                bitcnt <= 3'd0;
                phase <= 2'd0;
                acking <= 1'b0;
            end else begin
                case (state)
                    sbg_pkg::SBG_RX: if (scl_rise) begin
                        shreg <= rx_byte;
                        bitcnt <= bitcnt + 3'd1;
                        if (last_bit) begin
                            case (phase)
                                2'd0: begin
                                    reading <= rx_byte[0]; // [RULE_01]
                                    sent_count <= 1'b0;
                                    if (!rx_byte[0]) begin
                                        phase <= 2'd1;
                                    end
                                end
                                2'd1: begin
                                    idx <= rx_byte[3:0]; // [RULE_02]
                                    phase <= 2'd2;
                                end
                                2'd2: begin
                                    remain <= rx_byte; // [RULE_03]
                                    phase <= 2'd3;
                                end
                                default: if (remain != 8'd0) begin
                                    idx <= idx + 4'd1; // [RULE_17]
                                    remain <= remain - 8'd1;
                                end
                            endcase
                        end
                    end
                    sbg_pkg::SBG_RX_ACK: begin
                        if (scl_fall) begin
                            acking <= !acking;
                        end
                        bitcnt <= 3'd0;
                    end
                    sbg_pkg::SBG_TX: if (scl_fall) begin
                        bitcnt <= bitcnt + 3'd1;
                    end
                    sbg_pkg::SBG_TX_ACK: if (scl_rise && !sda) begin
                        if (sent_count) begin
                            idx <= idx + 4'd1; // [RULE_17] [RULE_08]
                        end
                        sent_count <= 1'b1;
                    end
                    default: bitcnt <= 3'd0;
                endcase
            end
        end
    end

    // Drive data low for acks and zero bits of transmitted bytes
    wire ack_drive = state == sbg_pkg::SBG_RX_ACK && acking; // [RULE_04]
    wire tx_drive = state == sbg_pkg::SBG_TX && !tx_byte[3'd7 - bitcnt];
    wire next_sda_oe = ack_drive || tx_drive;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
        end
    end

    a_ack_drive: assert property ( // [RULE_04]
        @(posedge ref_clk) disable iff (!resetn)
        ack_drive |=> sda_oe
    ) else $error("Acknowledge not driven on data");

    a_nak_release: assert property ( // [RULE_11]
        @(posedge ref_clk) disable iff (!resetn)
        state == sbg_pkg::SBG_TX_ACK && scl_rise && sda
        |=> state == sbg_pkg::SBG_SKIP
    ) else $error("Data still driven after not-acknowledge");

    a_index_step: assert property ( // [RULE_17]
        @(posedge ref_clk) disable iff (!resetn)
        state == sbg_pkg::SBG_TX_ACK && scl_rise && !sda && sent_count
        |=> idx == $past(idx) + 4'd1
    ) else $error("Register index did not advance");

    // Output gating, pins active low, register bit must be set too
    wire run0 =
        gate_reg[sbg_pkg::SBG_OE0_BIT] && !en0_sy[1]; // [RULE_14] [RULE_18]
    wire run1 =
        gate_reg[sbg_pkg::SBG_OE1_BIT] && !en1_sy[1]; // [RULE_13] [RULE_18]
    wire [1:0] dsel = dis_reg[1:0];
    wire dis_hiz = dsel == sbg_pkg::SBG_DIS_HIZ; // [RULE_16]
    wire dis_high = dsel == sbg_pkg::SBG_DIS_HIGH; // [RULE_16]
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            diff_out0_run <= 2'b00;
            diff_out1_run <= 2'b00;
            diff_out0_level <= 2'b00;
            diff_out1_level <= 2'b00;
            diff_out0_oe <= 2'b11;
            diff_out1_oe <= 2'b11;
        end else begin
            diff_out0_run <= {2{run0}};
            diff_out1_run <= {2{run1}};
            // Disabled pair shows the selected state on both legs
            diff_out0_level <= {2{!run0 && dis_high}}; // [RULE_15]
            diff_out1_level <= {2{!run1 && dis_high}}; // [RULE_15]
            diff_out0_oe <= {2{run0 || !dis_hiz}};
            diff_out1_oe <= {2{run1 || !dis_hiz}};
        end
    end

    a_run1_gate: assert property ( // [RULE_13]
        @(posedge ref_clk) disable iff (!resetn)
        diff_out1_run[0] |-> $past(gate_reg[sbg_pkg::SBG_OE1_BIT])
    ) else $error("Output 1 runs with its enable bit clear");

    a_run0_gate: assert property ( // [RULE_14]
        @(posedge ref_clk) disable iff (!resetn)
        diff_out0_run[0] |-> $past(gate_reg[sbg_pkg::SBG_OE0_BIT])
    ) else $error("Output 0 runs with its enable bit clear");

    a_dis_level: assert property ( // [RULE_15]
        @(posedge ref_clk) disable iff (!resetn)
        !diff_out1_run[0] |-> diff_out1_level == {2{$past(dis_high)}}
    ) else $error("Disabled output 1 shows the wrong level");

    a_hiz_oe: assert property ( // [RULE_16]
        @(posedge ref_clk) disable iff (!resetn)
        diff_out1_oe == 2'b00 |-> $past(dis_hiz) && !diff_out1_run[0]
    ) else $error("Output 1 released without high impedance select");

    a_pin_run: assert property ( // [RULE_18]
        @(posedge ref_clk) disable iff (!resetn)
        diff_out0_run[0] |-> !$past(en0_sy[1])
    ) else $error("Output 0 runs with its enable pin high");
endmodule
